// ### ute_pkg.sv
// Constants, register map and state codes of the unprivileged trap entry unit.
package ute_pkg;

	// ----------------------------------------------------------------
	// Register map, byte offsets within the slave window.
	// ----------------------------------------------------------------
	localparam logic [6:0] A_CMD  = 7'h00;
	localparam logic [6:0] A_STAT = 7'h04;
	localparam logic [6:0] A_STATUS = 7'h08;
	localparam logic [6:0] A_REG0 = 7'h10;
	localparam int         NREG   = 13;

	// Index of each 64-bit state register in the register array.
	localparam logic [3:0] I_PC      = 4'h0;
	localparam logic [3:0] I_SP      = 4'h1;
	localparam logic [3:0] I_USER_SP   = 4'h2;
	localparam logic [3:0] I_KERN_SP   = 4'h3;
	localparam logic [3:0] I_KERN_GLOB = 4'h4;
	localparam logic [3:0] I_GLOB      = 4'h5;
	localparam logic [3:0] I_ARG0      = 4'h6;
	localparam logic [3:0] I_ARG1      = 4'h7;
	localparam logic [3:0] I_ARG2      = 4'h8;
	localparam logic [3:0] I_RESULT  = 4'h9;
	localparam logic [3:0] I_UNIQUE  = 4'hA;
	localparam logic [3:0] I_VEC_IF  = 4'hB;
	localparam logic [3:0] I_VEC_SYS = 4'hC;

	// ----------------------------------------------------------------
	// Operation codes written to the command register.
	// ----------------------------------------------------------------
	localparam logic [2:0] OP_BPT     = 3'h0;
	localparam logic [2:0] OP_BUGCHK  = 3'h1;
	localparam logic [2:0] OP_GENTRAP = 3'h2;
	localparam logic [2:0] OP_CALLSYS = 3'h3;
	localparam logic [2:0] OP_RDUNIQ  = 3'h4;
	localparam logic [2:0] OP_WRUNIQ  = 3'h5;

	// Status register bit positions.
	localparam int ST_BUSY = 0;
	localparam int ST_KSNV = 1;
	localparam int ST_MCHK = 2;

	// ----------------------------------------------------------------
	// Processor status layout and values.
	// ----------------------------------------------------------------
	localparam int         STATUS_W        = 4;
	localparam int         STATUS_MODE_BIT = 3;
	localparam logic [3:0] STATUS_KERNEL   = 4'h0;
	localparam logic [3:0] STATUS_SYS_SAVE = 4'h8;

	// Handler codes placed in the first argument register.
	localparam logic [63:0] CODE_BPT     = 64'h0;
	localparam logic [63:0] CODE_BUGCHK  = 64'h1;
	localparam logic [63:0] CODE_GENTRAP = 64'h2;

	// Frame geometry.
	localparam int          FRAME_QW    = 6;
	localparam int          SYS_SLOTS   = 3;
	localparam logic [63:0] QW_BYTES    = 64'h8;
	localparam logic [63:0] INSTR_BYTES = 64'h4;
	localparam logic [63:0] QW_MASK     = 64'h7;

	// Sequencer states, one-hot.
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_CHECK = 4'b0010,
		S_STORE = 4'b0100,
		S_DISP  = 4'b1000
	} ute_state_e;

endpackage

// ### ute_trap_entry.sv
// Unprivileged trap entry sequencer with an AHB-Lite register slave.
//
// Contract
// - User-mode software trap swaps stacks, clears status.
// - Entry allocates six quadwords below kernel stack.
// - Traps save status, PC, global pointer, arguments.
// - Breakpoint puts zero in first argument.
// - Bugcheck puts one in first argument.
// - Generate trap puts two in first argument.
// - Global pointer loads kernel value after save.
// - Software traps dispatch through fault trap vector.
// - Saved PC is the following instruction.
// - Second and third arguments left unspecified.
// - Bad kernel stack raises stack-not-valid instead.
// - System call from kernel raises machine check.
// - User system call swaps stacks, builds frame.
// - Call frame saves status eight, PC and global pointer.
// - System call dispatches through its own vector.
// - Scratch registers unspecified on call entry.
// - Read unique copies value into result.
// - Write unique loads value from argument.
// - Status: bit 3 mode, bits 2-0 priority.
// - One unique register, reachable in any mode.
module ute_trap_entry #(
	parameter int FRAME_SLOTS = ute_pkg::FRAME_QW
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 ce,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output wire logic                 hreadyout,
	output wire logic                 hresp,
	output wire logic [31:0]          hrdata,
	input  wire logic                 stack_fault,
	output wire logic                 store_valid,
	output wire logic [63:0]          store_addr,
	output wire logic [63:0]          store_data,
	output wire logic                 exc_ksnv,
	output wire logic                 exc_mchk,
	output wire logic                 entry_done,
	output wire logic                 busy,
	output wire logic [3:0]           processor_status
);

	// ----------------------------------------------------------------
	// Elaboration check.
	// ----------------------------------------------------------------
	// The slot counter is three bits and the frame layout has six slots.
	if (FRAME_SLOTS != 6) begin : g_bad_frame
		$error("ute_trap_entry: FRAME_SLOTS must be 6");
	end

	// ----------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------
	logic [63:0]        gpr_r [ute_pkg::NREG];
	logic [3:0]         status_r;
	logic [3:0]         old_status_r;
	logic [63:0]        ret_pc_r;
	logic [2:0]         op_r;
	logic [2:0]         slot_r;
	ute_pkg::ute_state_e state_r;
	logic               ksnv_sticky_r;
	logic               mchk_sticky_r;
	logic               ksnv_pulse_r;
	logic               mchk_pulse_r;
	logic               done_r;
	logic               st_valid_r;
	logic [63:0]        st_addr_r;
	logic [63:0]        st_data_r;
	logic               wr_pend_r;
	logic               rd_pend_r;
	logic               map_ok_r;
	logic [6:0]         addr_r;
	logic               hreadyout_r;
	logic               hresp_r;
	logic [31:0]        hrdata_r;

	// ----------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------
	// An address phase is taken when the slave is selected, the bus is ready and htrans is NONSEQ or SEQ.
	wire        addr_take = ce & hsel & hready & htrans[1];
	wire        addr_map  = (haddr[31:7] == 25'h0);
	wire [6:0]  reg_off   = 7'(addr_r - ute_pkg::A_REG0);
	wire [3:0]  reg_idx   = reg_off[6:3];
	wire        reg_hit   = map_ok_r & (addr_r >= ute_pkg::A_REG0) &
	                        (reg_off[6:3] < 4'(ute_pkg::NREG)) & (addr_r[1:0] == 2'h0);
	wire [63:0] reg_word  = gpr_r[reg_idx];
	wire        is_idle   = (state_r == ute_pkg::S_IDLE);
	wire        wr_phase  = ce & wr_pend_r;
	wire        wr_cmd    = wr_phase & map_ok_r & (addr_r == ute_pkg::A_CMD) & is_idle;
	wire        wr_stat   = wr_phase & map_ok_r & (addr_r == ute_pkg::A_STAT);
	wire        wr_pstat  = wr_phase & map_ok_r & (addr_r == ute_pkg::A_STATUS) & is_idle;
	wire        wr_reg    = wr_phase & reg_hit & is_idle;
	wire        op_known  = (hwdata[2:0] <= ute_pkg::OP_WRUNIQ);

	// Read data selection for the captured address.
	wire [31:0] stat_word = {29'h0, mchk_sticky_r, ksnv_sticky_r, ~is_idle};
	wire [31:0] rd_word   =
		!map_ok_r                     ? 32'h0 :
		(addr_r == ute_pkg::A_STAT)   ? stat_word :
		(addr_r == ute_pkg::A_STATUS) ? {28'h0, status_r} :
		(reg_hit && addr_r[2])        ? reg_word[63:32] :
		reg_hit                       ? reg_word[31:0] : 32'h0;

	// ----------------------------------------------------------------
	// Sequencer decode.
	// ----------------------------------------------------------------
	wire        is_user   = status_r[ute_pkg::STATUS_MODE_BIT];
	wire        is_sys    = (op_r == ute_pkg::OP_CALLSYS);
	wire        is_trap   = (op_r <= ute_pkg::OP_GENTRAP);
	// Frame base is the kernel stack when entering from user mode.
	wire [63:0] stk_base  = is_user ? gpr_r[ute_pkg::I_KERN_SP] : gpr_r[ute_pkg::I_SP];
	wire [63:0] frame_sz  = 64'(FRAME_SLOTS) * ute_pkg::QW_BYTES;
	wire [63:0] new_sp    = stk_base - frame_sz;
	// A misaligned frame or a fault from the memory side means no valid stack.
	wire        stk_bad   = stack_fault | ((new_sp & ute_pkg::QW_MASK) != 64'h0);
	wire [2:0]  last_slot = is_sys ? 3'(ute_pkg::SYS_SLOTS - 1) : 3'(FRAME_SLOTS - 1);
	wire [63:0] arg0_code =
		(op_r == ute_pkg::OP_BPT)    ? ute_pkg::CODE_BPT :
		(op_r == ute_pkg::OP_BUGCHK) ? ute_pkg::CODE_BUGCHK :
		ute_pkg::CODE_GENTRAP;
	wire [63:0] disp_vec  = is_sys ? gpr_r[ute_pkg::I_VEC_SYS] :
	                                 gpr_r[ute_pkg::I_VEC_IF];
	wire [63:0] slot0_val = is_sys ? 64'(ute_pkg::STATUS_SYS_SAVE) :
	                                 64'(old_status_r);

	// Quadword stored for each frame slot; arguments stay live until dispatch.
	wire [63:0] slot_val  =
		(slot_r == 3'h0) ? slot0_val :
		(slot_r == 3'h1) ? ret_pc_r :
		(slot_r == 3'h2) ? gpr_r[ute_pkg::I_GLOB] :
		(slot_r == 3'h3) ? gpr_r[ute_pkg::I_ARG0] :
		(slot_r == 3'h4) ? gpr_r[ute_pkg::I_ARG1] :
		gpr_r[ute_pkg::I_ARG2];
	wire [63:0] slot_addr = gpr_r[ute_pkg::I_SP] + (64'(slot_r) * ute_pkg::QW_BYTES);

	// ----------------------------------------------------------------
	// AHB-Lite slave: writes take no wait state, reads take one.
	// ----------------------------------------------------------------
	// The read wait lets a write in the previous data phase land first.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			map_ok_r    <= 1'b0;
			addr_r      <= 7'h0;
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
			hrdata_r    <= 32'h0;
		end else if (ce) begin
			if (rd_pend_r) begin
				hrdata_r    <= rd_word;
				hreadyout_r <= 1'b1;
				rd_pend_r   <= 1'b0;
				wr_pend_r   <= 1'b0;
			end else begin
				wr_pend_r   <= addr_take & hwrite;
				rd_pend_r   <= addr_take & ~hwrite;
				hreadyout_r <= ~(addr_take & ~hwrite);
				if (addr_take) begin
					addr_r   <= haddr[6:0];
					map_ok_r <= addr_map;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags: a new event wins over a clear in the same cycle.
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ksnv_sticky_r <= 1'b0;
			mchk_sticky_r <= 1'b0;
		end else if (ce) begin
			ksnv_sticky_r <= ksnv_pulse_r |
			                 (ksnv_sticky_r & ~(wr_stat & hwdata[ute_pkg::ST_KSNV]));
			mchk_sticky_r <= mchk_pulse_r |
			                 (mchk_sticky_r & ~(wr_stat & hwdata[ute_pkg::ST_MCHK]));
		end
	end

	// ----------------------------------------------------------------
	// Entry sequencer and architectural state.
	// ----------------------------------------------------------------
	// Software writes state only while idle; the sequencer owns it otherwise.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < ute_pkg::NREG; i++) begin
				gpr_r[i] <= 64'h0;
			end
			status_r     <= ute_pkg::STATUS_KERNEL;
			old_status_r <= ute_pkg::STATUS_KERNEL;
			ret_pc_r     <= 64'h0;
			op_r         <= ute_pkg::OP_BPT;
			slot_r       <= 3'h0;
			state_r      <= ute_pkg::S_IDLE;
			ksnv_pulse_r <= 1'b0;
			mchk_pulse_r <= 1'b0;
			done_r       <= 1'b0;
			st_valid_r   <= 1'b0;
			st_addr_r    <= 64'h0;
			st_data_r    <= 64'h0;
		end else if (ce) begin
			ksnv_pulse_r <= 1'b0;
			mchk_pulse_r <= 1'b0;
			done_r       <= 1'b0;
			st_valid_r   <= 1'b0;
			case (state_r)
				ute_pkg::S_IDLE: begin
					if (wr_reg && addr_r[2]) begin
						gpr_r[reg_idx][63:32] <= hwdata;
					end else if (wr_reg) begin
						gpr_r[reg_idx][31:0] <= hwdata;
					end
					if (wr_pstat) begin
						status_r <= hwdata[ute_pkg::STATUS_W-1:0];
					end
					if (wr_cmd && op_known) begin
						op_r    <= hwdata[2:0];
						state_r <= ute_pkg::S_CHECK;
					end
				end
				ute_pkg::S_CHECK: begin
					slot_r   <= 3'h0;
					old_status_r <= status_r;
					ret_pc_r <= gpr_r[ute_pkg::I_PC] + ute_pkg::INSTR_BYTES;
					state_r  <= ute_pkg::S_IDLE;
					if (op_r == ute_pkg::OP_RDUNIQ) begin
						gpr_r[ute_pkg::I_RESULT] <= gpr_r[ute_pkg::I_UNIQUE];
						done_r <= 1'b1;
					end else if (op_r == ute_pkg::OP_WRUNIQ) begin
						gpr_r[ute_pkg::I_UNIQUE] <= gpr_r[ute_pkg::I_ARG0];
						done_r <= 1'b1;
					end else if (is_sys && !is_user) begin
						mchk_pulse_r <= 1'b1;
					end else if (stk_bad) begin
						ksnv_pulse_r <= 1'b1;
					end else begin
						if (is_user) begin
							gpr_r[ute_pkg::I_USER_SP] <= gpr_r[ute_pkg::I_SP];
							status_r <= ute_pkg::STATUS_KERNEL;
						end
						gpr_r[ute_pkg::I_SP] <= new_sp;
						state_r <= ute_pkg::S_STORE;
					end
				end
				ute_pkg::S_STORE: begin
					if (stack_fault) begin
						ksnv_pulse_r <= 1'b1;
						state_r      <= ute_pkg::S_IDLE;
					end else begin
						st_valid_r <= 1'b1;
						st_addr_r  <= slot_addr;
						st_data_r  <= slot_val;
						slot_r     <= 3'(slot_r + 3'h1);
						if (slot_r == last_slot) begin
							state_r <= ute_pkg::S_DISP;
						end
					end
				end
				ute_pkg::S_DISP: begin
					// Scratch and remaining argument registers are left as they are.
					if (is_trap) begin
						gpr_r[ute_pkg::I_ARG0] <= arg0_code;
					end
					gpr_r[ute_pkg::I_GLOB] <= gpr_r[ute_pkg::I_KERN_GLOB];
					gpr_r[ute_pkg::I_PC] <= disp_vec;
					done_r  <= 1'b1;
					state_r <= ute_pkg::S_IDLE;
				end
				default: begin
					state_r <= ute_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs taken from flip-flops; busy is the inverted idle bit of the state register.
	// ----------------------------------------------------------------
	assign hreadyout        = hreadyout_r;
	assign hresp            = hresp_r;
	assign hrdata           = hrdata_r;
	assign store_valid      = st_valid_r;
	assign store_addr       = st_addr_r;
	assign store_data       = st_data_r;
	assign exc_ksnv         = ksnv_pulse_r;
	assign exc_mchk         = mchk_pulse_r;
	assign entry_done       = done_r;
	assign busy             = ~state_r[0];
	assign processor_status = status_r;

endmodule

// ### ute_chk.sv
// Checker of bus timing, frame stores and exception pulses.
module ute_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        busy,
	input wire logic        store_valid,
	input wire logic [63:0] store_addr,
	input wire logic        exc_ksnv,
	input wire logic        exc_mchk,
	input wire logic        entry_done,
	input wire logic [3:0]  processor_status
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	logic       cmd_r;
	logic       err_r;
	logic [2:0] op_r;
	logic [3:0] cnt_r;
	// Decode of a taken transfer, an accepted command and its frame size.
	wire logic       take_w = hsel & hready & htrans[1];
	wire logic       go_w   = cmd_r & !busy & (hwdata[2:0] <= 3'h5);
	wire logic       kcall  = go_w & (hwdata[2:0] == ute_pkg::OP_CALLSYS) & !processor_status[3];
	wire logic [3:0] exp_w  = (op_r < 3'h3) ? 4'h6 : (op_r == 3'h3) ? 4'h3 : 4'h0;
	// Tracks the command data phase and counts stores since it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_r <= 1'b0;
			err_r <= 1'b0;
			op_r  <= 3'h0;
			cnt_r <= 4'h0;
		end else begin
			cmd_r <= take_w & hwrite & (haddr == 32'h0);
			err_r <= go_w ? 1'b0 : (err_r | exc_ksnv | exc_mchk);
			op_r  <= go_w ? hwdata[2:0] : op_r;
			cnt_r <= go_w ? 4'h0 : cnt_r + {3'h0, store_valid};
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_read_wait: assert property (take_w & !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase not two cycles");
	a_write_nowait: assert property (take_w & hwrite |=> hreadyout)
		else $error("write data phase stalled");
	a_store_kernel: assert property (
		store_valid |-> processor_status == ute_pkg::STATUS_KERNEL)
		else $error("store issued outside kernel mode");
	a_store_align: assert property (store_valid |-> store_addr[2:0] == 3'h0)
		else $error("store to unaligned stack");
	a_store_step: assert property (
		store_valid && $past(store_valid) |-> store_addr == $past(store_addr) + 64'h8)
		else $error("frame slots not consecutive");
	a_frame_count: assert property (
		entry_done && !(err_r | exc_ksnv | exc_mchk) |-> cnt_r == exp_w)
		else $error("wrong number of frame stores");
	a_mchk_kernel: assert property (kcall |-> ##[1:3] exc_mchk)
		else $error("kernel call without machine check");
	a_mchk_nostore: assert property (kcall |=> !store_valid [*6])
		else $error("kernel call stored a frame");
	a_ksnv_stop: assert property (exc_ksnv |=> !store_valid [*4])
		else $error("store after stack fault");
	a_done_pulse: assert property (entry_done |=> !entry_done)
		else $error("done longer than one cycle");
endmodule

// ### testbench.sv
// Self-checking bench of the trap entry unit over its bus.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic         hclk        = 1'b0;
	logic         hresetn     = 1'b0;
	logic         hsel        = 1'b0;
	logic         hwrite      = 1'b0;
	logic         stack_fault = 1'b0;
	logic [1:0]   htrans      = 2'h0;
	logic [31:0]  haddr       = 32'h0;
	logic [31:0]  hwdata      = 32'h0;
	logic [31:0]  rd, pc, sp, kernel_stack_ptr, arg0, arg1, arg2;
	logic [63:0]  base;
	logic [63:0]  sv [6];
	logic [127:0] exp_q [$];
	int           seed        = 32'hE00B3666;
	int           num_errors  = 0;
	int           num_checks  = 0;
	int           cyc         = 0;
	wire logic        hreadyout, hresp, store_valid, exc_ksnv, exc_mchk, entry_done, busy;
	wire logic [31:0] hrdata;
	wire logic [63:0] store_addr, store_data;
	wire logic [3:0]  processor_status;
	ute_trap_entry u_ute_trap_entry (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .stack_fault(stack_fault), .store_valid(store_valid),
		.store_addr(store_addr), .store_data(store_data), .exc_ksnv(exc_ksnv),
		.exc_mchk(exc_mchk), .entry_done(entry_done), .busy(busy),
		.processor_status(processor_status));
	// Clock of 40 ns period.
	always #20 hclk = ~hclk;
	// Compares one value and reports a mismatch.
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish;
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One single AHB-Lite transfer; read data is taken at the closing edge.
	task automatic bus(input logic [6:0] a, input logic w, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {25'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check({96'h0, rd}, {96'h0, exp});
	endtask
	function automatic logic [6:0] ra(input logic [3:0] i);
		return ute_pkg::A_REG0 + {i, 3'h0};
	endfunction
	// Starts an operation and waits until the sequencer is idle again.
	task automatic run(input logic [2:0] op);
		bus(ute_pkg::A_CMD, 1'b1, {29'h0, op});
		repeat (2) @(posedge hclk);
		while (busy !== 1'b0) @(posedge hclk);
	endtask
	// Takes the oldest expected store whenever a store appears.
	always @(posedge hclk) begin
		cyc++;
		if (store_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check(128'h1, 128'h0);
			else
				check({store_addr, store_data}, exp_q.pop_front());
		end
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// Main sequence.
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc(ute_pkg::A_STATUS, 32'h0);
		rdc(7'h78, 32'h0);
		bus(ra(ute_pkg::I_KERN_GLOB), 1'b1, 32'hA0);
		bus(ra(ute_pkg::I_VEC_IF), 1'b1, 32'hC00);
		bus(ra(ute_pkg::I_VEC_SYS), 1'b1, 32'hD00);
		for (int op = 0; op < 4; op++) begin
			arg0 = $random(seed);
			arg1 = $random(seed);
			arg2 = $random(seed);
			sp  = $random(seed);
			pc  = $random(seed) & 32'hFFFFFFFC;
			kernel_stack_ptr = $random(seed) & 32'hFFFFFFF8;
			bus(ra(ute_pkg::I_SP), 1'b1, sp);
			bus(ra(ute_pkg::I_KERN_SP), 1'b1, kernel_stack_ptr);
			bus(ra(ute_pkg::I_GLOB), 1'b1, 32'hB0);
			bus(ra(ute_pkg::I_ARG0), 1'b1, arg0);
			bus(ra(ute_pkg::I_ARG1), 1'b1, arg1);
			bus(ra(ute_pkg::I_ARG2), 1'b1, arg2);
			bus(ra(ute_pkg::I_PC), 1'b1, pc);
			bus(ute_pkg::A_STATUS, 1'b1, 32'h8);
			base  = {32'h0, kernel_stack_ptr} - 64'd48;
			sv[0] = 64'h8;
			sv[1] = {32'h0, pc} + 64'h4;
			sv[2] = 64'hB0;
			sv[3] = {32'h0, arg0};
			sv[4] = {32'h0, arg1};
			sv[5] = {32'h0, arg2};
			for (int i = 0; i < (op == 3 ? 3 : 6); i++)
				exp_q.push_back({base + 64'(8 * i), sv[i]});
			run(3'(op));
			rdc(ra(ute_pkg::I_SP), base[31:0]);
			rdc(ra(ute_pkg::I_USER_SP), sp);
			rdc(ute_pkg::A_STATUS, 32'h0);
			rdc(ra(ute_pkg::I_GLOB), 32'hA0);
			rdc(ra(ute_pkg::I_PC), op == 3 ? 32'hD00 : 32'hC00);
			rdc(ra(ute_pkg::I_ARG0), op == 3 ? arg0 : op);
		end
		check({96'h0, 32'(exp_q.size())}, 128'h0);
		bus(ute_pkg::A_STATUS, 1'b1, 32'h0);
		run(ute_pkg::OP_CALLSYS);
		rdc(ute_pkg::A_STAT, 32'h4);
		bus(ute_pkg::A_STAT, 1'b1, 32'h6);
		bus(ra(ute_pkg::I_KERN_SP), 1'b1, 32'h8004);
		bus(ute_pkg::A_STATUS, 1'b1, 32'h8);
		run(ute_pkg::OP_BPT);
		rdc(ute_pkg::A_STAT, 32'h2);
		rdc(ute_pkg::A_STATUS, 32'h8);
		bus(ute_pkg::A_STAT, 1'b1, 32'h6);
		bus(ute_pkg::A_STATUS, 1'b1, 32'h0);
		stack_fault <= 1'b1;
		run(ute_pkg::OP_BUGCHK);
		stack_fault <= 1'b0;
		rdc(ute_pkg::A_STAT, 32'h2);
		bus(ute_pkg::A_STAT, 1'b1, 32'h6);
		for (int m = 0; m < 2; m++) begin
			arg0 = $random(seed);
			bus(ute_pkg::A_STATUS, 1'b1, m == 0 ? 32'h0 : 32'h8);
			bus(ra(ute_pkg::I_ARG0), 1'b1, arg0);
			run(ute_pkg::OP_WRUNIQ);
			bus(ra(ute_pkg::I_ARG0), 1'b1, 32'h0);
			run(ute_pkg::OP_RDUNIQ);
			rdc(ra(ute_pkg::I_RESULT), arg0);
			rdc(ra(ute_pkg::I_UNIQUE), arg0);
			rdc(ute_pkg::A_STAT, 32'h0);
		end
		tally_and_finish();
	end
endmodule
bind ute_trap_entry ute_chk u_ute_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .busy(busy), .store_valid(store_valid),
	.store_addr(store_addr), .exc_ksnv(exc_ksnv), .exc_mchk(exc_mchk),
	.entry_done(entry_done), .processor_status(processor_status));
